// *** rtl/pfta_flash_ctrl.sv ***
// Program flash controller reached through table reads and writes over AHB-Lite.
// Assumes one synchronous clock, an instruction fetch port from the core, and an
// external data EEPROM engine behind a start/done handshake.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

module pfta_flash_ctrl #(
  parameter int PROG_CYCLES = pfta_pkg::PROG_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Interrupt
  output logic irq,
  // Instruction fetch
  input wire logic fetchReq,
  input wire logic [14:0] fetchAddr,
  output logic [15:0] fetchData,
  output logic fetchValid,
  output logic fetchStall,
  // Data EEPROM engine
  output logic eepromStart,
  input wire logic eepromDone
);

  localparam int TMR_W = $clog2(PROG_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PROG_CYCLES - 1);

  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] off);
    regHit = (addr[7:2] == off[7:2]);
  endfunction

  function automatic logic [15:0] decodeWord(input logic [15:0] word);
    if ((word & pfta_pkg::ILLEGAL_MASK) == pfta_pkg::ILLEGAL_VALUE) begin
      decodeWord = pfta_pkg::NOP_WORD;
    end else begin
      decodeWord = word;
    end
  endfunction

  logic [15:0] progMem [0:pfta_pkg::PM_WORDS-1];
  logic [7:0] hold [0:pfta_pkg::WBLOCK_BYTES-1];
  pfta_pkg::pfta_ctrl_t ctrl;
  pfta_pkg::pfta_state_t state;
  logic [15:0] tablePtr;
  logic [7:0] tableLatch;
  logic [1:0] status;
  logic [1:0] mask;
  logic [15:0] blkBase;
  logic isErase;
  logic [4:0] wordCnt;
  logic [TMR_W-1:0] timer;
  logic wrPend;
  logic rdPend;
  logic [7:0] regAddr;

  // Bus decode
  logic addrPhase;
  logic ctrlWr;
  logic opWr;
  logic startCmd;
  logic bulkReq;
  logic opRead;
  logic opWrite;
  logic opDone;
  logic [4:0] lastWord;
  logic [14:0] burnAddr;
  logic [15:0] progWord;
  logic [7:0] readByte;
  logic [1:0] next_status;

  assign addrPhase = hsel && htrans[1] && hready;
  assign ctrlWr = wrPend && regHit(regAddr, pfta_pkg::ADDR_CTRL);
  assign opWr = wrPend && regHit(regAddr, pfta_pkg::ADDR_OP);
  assign startCmd = ctrlWr && hwdata[pfta_pkg::CTRL_START] && hwdata[pfta_pkg::CTRL_WREN]
    && (state == pfta_pkg::IDLE);
  assign bulkReq = ctrlWr && hwdata[pfta_pkg::CTRL_BULK];
  assign opRead = opWr && hwdata[pfta_pkg::OP_READ] && (state == pfta_pkg::IDLE);
  assign opWrite = opWr && hwdata[pfta_pkg::OP_WRITE] && (state == pfta_pkg::IDLE);
  assign opDone = ((state == pfta_pkg::TIMED) && (timer == TMR_LAST))
    || ((state == pfta_pkg::EEPROM) && eepromDone);
  assign lastWord = isErase ? pfta_pkg::EBLOCK_LAST : pfta_pkg::WBLOCK_LAST;
  assign burnAddr = isErase ? {blkBase[15:6], wordCnt}
    : {blkBase[15:3], wordCnt[1:0]};
  assign progWord = {hold[{wordCnt[1:0], 1'b1}], hold[{wordCnt[1:0], 1'b0}]};
  assign readByte = tablePtr[0] ? progMem[tablePtr[15:1]][15:8]
    : progMem[tablePtr[15:1]][7:0];
  assign next_status = (status
    & ~((wrPend && regHit(regAddr, pfta_pkg::ADDR_STAT)) ? hwdata[1:0] : 2'h0))
    | {bulkReq, opDone};

  // AHB-Lite address phase capture, one wait state on reads
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      regAddr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend <= addrPhase && hwrite;
      rdPend <= addrPhase && !hwrite;
      hreadyout <= !(addrPhase && !hwrite);
      hresp <= 1'b0;
      if (addrPhase) begin
        regAddr <= haddr[7:0];
      end
    end
  end

  // Read data, unmapped offsets read zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rdPend) begin
      if (regHit(regAddr, pfta_pkg::ADDR_CTRL)) begin
        hrdata <= {27'h0, ctrl};
      end else if (regHit(regAddr, pfta_pkg::ADDR_PTR)) begin
        hrdata <= {16'h0, tablePtr};
      end else if (regHit(regAddr, pfta_pkg::ADDR_LATCH)) begin
        hrdata <= {24'h0, tableLatch};
      end else if (regHit(regAddr, pfta_pkg::ADDR_STAT)) begin
        hrdata <= {30'h0, status};
      end else if (regHit(regAddr, pfta_pkg::ADDR_MASK)) begin
        hrdata <= {30'h0, mask};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Control register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= pfta_pkg::CTRL_RESET;
    end else begin
      if (ctrlWr) begin
        ctrl.erase <= hwdata[pfta_pkg::CTRL_ERASE];
        ctrl.msel <= hwdata[pfta_pkg::CTRL_MSEL];
        ctrl.wren <= hwdata[pfta_pkg::CTRL_WREN];
      end
      ctrl.bulk <= 1'b0;
      if (startCmd) begin
        ctrl.start <= 1'b1;
      end else if (opDone) begin
        ctrl.start <= 1'b0;
      end
    end
  end

  // Table pointer and table latch
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tablePtr <= pfta_pkg::PTR_RESET;
      tableLatch <= pfta_pkg::LATCH_RESET;
    end else begin
      if (wrPend && regHit(regAddr, pfta_pkg::ADDR_PTR)) begin
        tablePtr <= hwdata[15:0];
      end else if ((opRead || opWrite) && hwdata[pfta_pkg::OP_INC]) begin
        tablePtr <= tablePtr + 16'h0001;
      end
      if (opRead) begin
        tableLatch <= readByte;
      end else if (wrPend && regHit(regAddr, pfta_pkg::ADDR_LATCH)) begin
        tableLatch <= hwdata[7:0];
      end
    end
  end

  // Holding registers, refilled with erased bytes once a block is committed
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < pfta_pkg::WBLOCK_BYTES; i++) begin
        hold[i] <= pfta_pkg::HOLD_RESET;
      end
    end else if (opDone && !isErase && (state == pfta_pkg::TIMED)) begin
      for (int i = 0; i < pfta_pkg::WBLOCK_BYTES; i++) begin
        hold[i] <= pfta_pkg::HOLD_RESET;
      end
    end else if (opWrite) begin
      hold[tablePtr[2:0]] <= tableLatch;
    end
  end

  // Sequencer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= pfta_pkg::IDLE;
      blkBase <= 16'h0000;
      isErase <= 1'b0;
      wordCnt <= 5'h00;
      timer <= '0;
    end else begin
      unique case (state)
        pfta_pkg::IDLE: begin
          if (startCmd) begin
            blkBase <= tablePtr;
            isErase <= hwdata[pfta_pkg::CTRL_ERASE];
            wordCnt <= 5'h00;
            if (hwdata[pfta_pkg::CTRL_MSEL]) begin
              state <= pfta_pkg::BURN;
            end else begin
              state <= pfta_pkg::EEPROM;
            end
          end
        end
        pfta_pkg::BURN: begin
          wordCnt <= wordCnt + 5'h01;
          if (wordCnt == lastWord) begin
            timer <= '0;
            state <= pfta_pkg::TIMED;
          end
        end
        pfta_pkg::TIMED: begin
          timer <= timer + TMR_W'(1);
          if (timer == TMR_LAST) begin
            state <= pfta_pkg::IDLE;
          end
        end
        pfta_pkg::EEPROM: begin
          if (eepromDone) begin
            state <= pfta_pkg::IDLE;
          end
        end
      endcase
    end
  end

  // Flash array update, one word per cycle during the burn phase
  always_ff @(posedge sys_clk) begin
    if (state == pfta_pkg::BURN) begin
      if (isErase) begin
        progMem[burnAddr] <= pfta_pkg::ERASED_WORD;
      end else begin
        progMem[burnAddr] <= progWord;
      end
    end
  end

  // Status, mask and interrupt; a new event wins over a same-cycle clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= pfta_pkg::STAT_RESET;
      mask <= pfta_pkg::MASK_RESET;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      if (wrPend && regHit(regAddr, pfta_pkg::ADDR_MASK)) begin
        mask <= hwdata[pfta_pkg::ST_W-1:0];
        irq <= |(next_status & hwdata[pfta_pkg::ST_W-1:0]);
      end else begin
        irq <= |(next_status & mask);
      end
    end
  end

  // Instruction fetch, held off while an operation runs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchStall <= 1'b0;
      fetchValid <= 1'b0;
      fetchData <= 16'h0000;
      eepromStart <= 1'b0;
    end else begin
      if (startCmd) begin
        fetchStall <= 1'b1;
      end else if (opDone) begin
        fetchStall <= 1'b0;
      end
      fetchValid <= fetchReq && (state == pfta_pkg::IDLE) && !startCmd;
      if (fetchReq) begin
        fetchData <= decodeWord(progMem[fetchAddr]);
      end
      eepromStart <= startCmd && !hwdata[pfta_pkg::CTRL_MSEL];
    end
  end

endmodule

// *** common/pfta_pkg.sv ***
// Constants, register map and types of the program flash table access block.
// Assumes a single 25 MHz clock and an AHB-Lite slave port with 32-bit data.
package pfta_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PTR = 8'h04;
  localparam logic [7:0] ADDR_LATCH = 8'h08;
  localparam logic [7:0] ADDR_OP = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;

  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_ERASE = 1;
  localparam int CTRL_MSEL = 2;
  localparam int CTRL_WREN = 3;
  localparam int CTRL_BULK = 4;

  // Operation register fields
  localparam int OP_READ = 0;
  localparam int OP_WRITE = 1;
  localparam int OP_INC = 2;

  // Status and mask fields
  localparam int ST_DONE = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_W = 2;

  // Reset values
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [7:0] HOLD_RESET = 8'hff;

  // Program memory geometry
  localparam int PM_WORDS = 32768;
  localparam int WBLOCK_BYTES = 8;
  localparam int EBLOCK_BYTES = 64;
  localparam logic [4:0] WBLOCK_LAST = 5'h03;
  localparam logic [4:0] EBLOCK_LAST = 5'h1f;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // Fetch decode: words matching the pattern do not decode and run as no-operation
  localparam logic [15:0] ILLEGAL_MASK = 16'hff00;
  localparam logic [15:0] ILLEGAL_VALUE = 16'h0100;
  localparam logic [15:0] NOP_WORD = 16'h0000;

  // Programming timer
  localparam int CLK_MHZ = 25;
  localparam int PROG_TIME_US = 1000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic bulk;
    logic wren;
    logic msel;
    logic erase;
    logic start;
  } pfta_ctrl_t;

  typedef enum logic [1:0] {IDLE, BURN, TIMED, EEPROM} pfta_state_t;

endpackage

// *** verification/pfta_flash_ctrl_sva.sv ***
// Checker for the flash table access block, watching its top ports.
// Assumes one clock and PROG_CYCLES handed on by the bind.
`timescale 1ns/1ps
module pfta_flash_ctrl_sva #(
  parameter int PROG_CYCLES = 20
) (
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Fetch and data EEPROM
  input wire logic fetchReq,
  input wire logic [15:0] fetchData,
  input wire logic fetchValid,
  input wire logic fetchStall,
  input wire logic eepromStart
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [15:0] stallCnt;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) stallCnt <= 16'h0000;
    else stallCnt <= fetchStall ? stallCnt + 16'h0001 : 16'h0000;
  end
  sequence s_read_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_wait_data;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (s_read_taken |=> s_wait_data)
    else $error("read data phase not one wait cycle");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_stall_fetch: assert property (fetchStall |-> !fetchValid)
    else $error("fetch answered during operation");
  a_valid_cause: assert property (fetchValid |-> $past(fetchReq) && !$past(fetchStall))
    else $error("fetch answer without idle request");
  a_nop_decode: assert property (fetchValid |-> (fetchData & 16'hff00) != 16'h0100)
    else $error("non-decoding word passed to core");
  a_ee_pulse: assert property (eepromStart |=> !eepromStart)
    else $error("eeprom start longer than a pulse");
  a_timer_bound: assert property (stallCnt <= 16'(PROG_CYCLES + 40))
    else $error("operation not ended by timer");
endmodule

bind pfta_flash_ctrl pfta_flash_ctrl_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
  .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .fetchReq(fetchReq), .fetchData(fetchData),
  .fetchValid(fetchValid), .fetchStall(fetchStall), .eepromStart(eepromStart));

// *** verification/pfta_core_model.sv ***
// Model of the core fetch port and of the data EEPROM engine.
// Assumes the block's clock and reset; fetchGo is a one-cycle command.
`timescale 1ns/1ps
module pfta_core_model #(
  parameter int DONE_DELAY = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Fetch port
  input wire logic fetchGo,
  input wire logic fetchValid,
  output logic fetchReq,
  // Data EEPROM engine
  input wire logic eepromStart,
  output logic eepromDone
);
  int doneCnt;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) fetchReq <= 1'b0;
    else if (fetchReq && fetchValid) fetchReq <= 1'b0;
    else if (fetchGo) fetchReq <= 1'b1;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      doneCnt <= 0;
      eepromDone <= 1'b0;
    end else begin
      eepromDone <= (doneCnt == 1);
      if (eepromStart) doneCnt <= DONE_DELAY;
      else if (doneCnt != 0) doneCnt <= doneCnt - 1;
    end
  end
endmodule

// *** verification/test_program_flash_table_access.sv ***
// Testbench for the flash table access block over AHB-Lite.
// Assumes the block, its checker bind and the core model compiled first.
`timescale 1ns/1ps
module test_program_flash_table_access;
  localparam logic [7:0] CTL = pfta_pkg::ADDR_CTRL;
  localparam logic [7:0] PTR = pfta_pkg::ADDR_PTR;
  localparam logic [7:0] LAT = pfta_pkg::ADDR_LATCH;
  localparam logic [7:0] OP = pfta_pkg::ADDR_OP;
  localparam logic [7:0] STA = pfta_pkg::ADDR_STAT;
  localparam logic [7:0] MSK = pfta_pkg::ADDR_MASK;
  logic sys_clk, reset_n, hsel, hwrite, hreadyout, hresp, irq, fetchGo;
  logic fetchReq, fetchValid, fetchStall, eepromStart, eepromDone;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [14:0] fetchAddr;
  logic [15:0] fetchData;
  int bad_count, compares, eeCount;
  pfta_flash_ctrl #(.PROG_CYCLES(20)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .fetchData(fetchData), .fetchValid(fetchValid), .fetchStall(fetchStall),
    .eepromStart(eepromStart), .eepromDone(eepromDone));
  pfta_core_model u_core (.sys_clk(sys_clk), .reset_n(reset_n), .fetchGo(fetchGo),
    .fetchValid(fetchValid), .fetchReq(fetchReq), .eepromStart(eepromStart),
    .eepromDone(eepromDone));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (eepromStart === 1'b1) eeCount++;
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic hang(input string n);
    bad_count++;
    $display("Error %s timed out", n);
    report_and_stop();
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) hang("bus ready");
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h00000000, r);
    chk(n, e, r & m);
  endtask
  task automatic rbyte(input logic [15:0] a, input logic [7:0] e);
    wr(PTR, {16'h0000, a});
    wr(OP, 32'h00000001);
    rdc("latch byte", LAT, 32'h000000ff, {24'h000000, e});
  endtask
  task automatic wait_idle();
    int n;
    // Stall rises only after the start edge
    @(posedge sys_clk);
    for (n = 0; n < 200 && fetchStall === 1'b1; n++) @(posedge sys_clk);
    if (n >= 200) hang("operation end");
  endtask
  task automatic fetch(input logic [14:0] a, input logic [15:0] e);
    int n;
    // Let the repeat answer to a still-held earlier request pass
    @(posedge sys_clk);
    fetchAddr <= a;
    fetchGo <= 1'b1;
    @(posedge sys_clk);
    fetchGo <= 1'b0;
    for (n = 0; n < 200 && fetchValid !== 1'b1; n++) @(posedge sys_clk);
    if (n >= 200) hang("fetch");
    chk("fetch word", {16'h0000, e}, {16'h0000, fetchData});
    chk("stall at fetch", 32'h0, {31'h0, fetchStall});
  endtask
  function automatic logic [7:0] pb(input logic [2:0] k);
    return (k == 3'h3) ? 8'h01 : (8'ha0 | {5'h00, k});
  endfunction
  task automatic t_reset();
    logic [7:0] offs [7] = '{CTL, PTR, LAT, OP, STA, MSK, 8'h18};
    foreach (offs[i]) rdc("reset value", offs[i], 32'hffffffff, 32'h0);
    chk("irq idle", 32'h0, {31'h0, irq});
    $display("t_reset done");
  endtask
  task automatic t_erase();
    wr(PTR, 32'h00000047);
    wr(CTL, 32'h0000000f);
    @(posedge sys_clk);
    chk("stall", 32'h1, {31'h0, fetchStall});
    wr(CTL, 32'h0000000e);
    rdc("start held", CTL, 32'h1, 32'h1);
    fetch(15'h0020, 16'hffff);
    wait_idle();
    rdc("start cleared", CTL, 32'h1, 32'h0);
    rdc("done flag", STA, 32'h3, 32'h1);
    rbyte(16'h0040, 8'hff);
    rbyte(16'h007f, 8'hff);
    wr(STA, 32'h00000001);
    rdc("flag cleared", STA, 32'h3, 32'h0);
    $display("t_erase done");
  endtask
  task automatic t_program();
    wr(PTR, 32'h00000045);
    for (int i = 0; i < 8; i++) begin
      wr(LAT, {24'h000000, pb(3'(5 + i))});
      wr(OP, 32'h00000006);
    end
    rbyte(16'h0042, 8'hff);
    wr(PTR, 32'h00000046);
    wr(CTL, 32'h0000000d);
    wait_idle();
    for (int k = 0; k < 8; k++) rbyte(16'h0040 + 16'(k), pb(3'(k)));
    rbyte(16'h0048, 8'hff);
    wr(STA, 32'h00000001);
    $display("t_program done");
  endtask
  task automatic t_fetch();
    fetch(15'h0020, 16'ha1a0);
    fetch(15'h0021, 16'h0000);
    $display("t_fetch done");
  endtask
  task automatic t_bulk();
    wr(CTL, 32'h00000018);
    @(posedge sys_clk);
    chk("no stall", 32'h0, {31'h0, fetchStall});
    rdc("refused", STA, 32'h3, 32'h2);
    rdc("bulk bit", CTL, 32'h10, 32'h0);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(MSK, 32'h00000002);
    rdc("mask", MSK, 32'h3, 32'h2);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(STA, 32'h00000002);
    rdc("cleared", STA, 32'h3, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("t_bulk done");
  endtask
  task automatic t_eeprom();
    wr(CTL, 32'h00000009);
    wait_idle();
    rdc("eeprom done", STA, 32'h3, 32'h1);
    chk("eeprom starts", 32'h1, 32'(eeCount));
    $display("t_eeprom done");
  endtask
  initial begin
    {reset_n, hsel, hwrite, fetchGo} = 4'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    fetchAddr = 15'h0000;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_erase();
    t_program();
    t_fetch();
    t_bulk();
    t_eeprom();
    report_and_stop();
  end
endmodule
